// ===== hw/lpc_flash_target.v
`timescale 1ns/1ps
`default_nettype none
`include "lpc_target_defs.vh"
module lpc_flash_target #(
    parameter ACCEPT_CYC = `LPC_RST_ACCEPT_CYC,
    parameter [31:0] PIN_STATUS_ADDR = `LPC_PIN_STATUS_ADDR
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // LPC bus pins, sampled on clk_sys
    input wire frame_n,
    input wire [3:0] lad_in,
    output reg [3:0] lad_out,
    output reg lad_oe,
    // Pins
    input wire [4:0] general_purpose_inputs,
    // Memory array side
    output reg mem_rd,
    output reg mem_wr,
    output reg [31:0] mem_addr,
    output reg [7:0] mem_wdata,
    input wire [7:0] mem_rdata,
    input wire mem_ready,
    input wire mem_error,
    // Status
    output reg bus_active
);

    ////////////////////////////////////////////////////////////////////
    localparam S_IDLE = 4'd0;
    localparam S_TYPE = 4'd1;
    localparam S_ADDR = 4'd2;
    localparam S_WDATA = 4'd3;
    localparam S_HTAR1 = 4'd4;
    localparam S_HTAR2 = 4'd5;
    localparam S_SYNC = 4'd6;
    localparam S_RDATA = 4'd7;
    localparam S_DTAR1 = 4'd8;
    localparam S_DTAR2 = 4'd9;

    wire frame_n_s;
    wire [3:0] lad_s;
    wire [4:0] pins_s;

    // External pins cross into clk_sys through two flops
    lpc_sync2 #(.W(10)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d({frame_n, lad_in, general_purpose_inputs}),
        .q({frame_n_s, lad_s, pins_s})
    );

    reg [3:0] state;
    reg is_write;
    reg nib;
    reg [3:0] cnt;
    reg [7:0] data;
    reg pend;
    reg [15:0] wake;

    // Memory-cycle type check, used for the type field only
    function is_mem_type;
        input [3:0] t;
        begin
            is_mem_type = (t[3:2] == `LPC_TYPE_MEM);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Cycle state machine. Async reset floats the bus at once, well
    // inside the float window, since lad_oe is a reset flop.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            lad_oe <= 1'b0;
            lad_out <= 4'h0;
            is_write <= 1'b0;
            nib <= 1'b0;
            cnt <= 4'h0;
            data <= 8'h00;
            pend <= 1'b0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 8'h00;
            bus_active <= 1'b0;
            wake <= 16'h0000;
        end else begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            // Ignore the bus briefly after reset, still within 1 us
            if (wake != ACCEPT_CYC[15:0]) begin
                wake <= wake + 16'h0001;
            end else if (!frame_n_s && lad_s == `LPC_START) begin
                // Start seen (or restarted): abort any cycle in flight
                state <= S_TYPE;
                lad_oe <= 1'b0;
                bus_active <= 1'b1;
            end else begin
                case (state)
                    S_IDLE: begin
                        // Nothing driven between cycles
                        lad_oe <= 1'b0;
                        bus_active <= 1'b0;
                    end
                    S_TYPE: begin
                        if (is_mem_type(lad_s)) begin
                            is_write <= lad_s[1];
                            cnt <= 4'h0;
                            state <= S_ADDR;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                    S_ADDR: begin
                        // Most significant nibble first
                        mem_addr <= {mem_addr[27:0], lad_s};
                        cnt <= cnt + 4'h1;
                        if (cnt == `LPC_ADDR_NIBBLES - 4'h1) begin
                            nib <= 1'b0;
                            state <= is_write ? S_WDATA : S_HTAR1;
                        end
                    end
                    S_WDATA: begin
                        // Low nibble first, high nibble second
                        if (!nib) begin
                            data[3:0] <= lad_s;
                            nib <= 1'b1;
                        end else begin
                            data[7:4] <= lad_s;
                            state <= S_HTAR1;
                        end
                    end
                    S_HTAR1: begin
                        // Host drives 1111 now; nothing to do but count
                        state <= S_HTAR2;
                    end
                    S_HTAR2: begin
                        // Host releases; we take the bus next clock
                        state <= S_SYNC;
                        pend <= 1'b1;
                        if (is_write) begin
                            mem_wr <= 1'b1;
                            mem_wdata <= data;
                        end else if (mem_addr != PIN_STATUS_ADDR) begin
                            mem_rd <= 1'b1;
                        end
                    end
                    S_SYNC: begin
                        lad_oe <= 1'b1;
                        pend <= 1'b0;
                        if (is_write || mem_addr != PIN_STATUS_ADDR) begin
                            if (!pend && (mem_ready || mem_error)) begin
                                // An error sync on a read still carries both data nibbles
                                data <= is_write ? data : mem_rdata;
                                lad_out <= mem_error ? `LPC_SYNC_ERROR
                                                     : `LPC_SYNC_READY;
                                nib <= 1'b0;
                                state <= is_write ? S_DTAR1 : S_RDATA;
                            end else begin
                                lad_out <= `LPC_SYNC_LONG;
                            end
                        end else begin
                            // Live input levels, reserved bits zero
                            data <= {3'h0, pins_s};
                            lad_out <= `LPC_SYNC_READY;
                            nib <= 1'b0;
                            state <= S_RDATA;
                        end
                    end
                    S_RDATA: begin
                        if (!nib) begin
                            lad_out <= data[3:0];
                            nib <= 1'b1;
                        end else begin
                            lad_out <= data[7:4];
                            state <= S_DTAR1;
                        end
                    end
                    S_DTAR1: begin
                        lad_out <= `LPC_TAR_DRIVE;
                        state <= S_DTAR2;
                    end
                    S_DTAR2: begin
                        lad_oe <= 1'b0;
                        state <= S_IDLE;
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/lpc_sync2.v
`timescale 1ns/1ps
`default_nettype none
module lpc_sync2 #(
    parameter W = 1
) (
    input wire clk_sys,
    input wire rst,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta;

    // Two-stage synchroniser; first stage feeds only the second
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== shared/lpc_target_defs.vh
// Overview of operation
// - Type nibble bits 3:2 are 01; bit 1 picks read or write; bit 0 ignored.
// - Turnaround is two clocks: last driver sends 1111, then releases the bus.
// - Device may insert sync clocks: ready 0000, short 0101, long 0110, error 1010.
// - Data byte moves in two clocks, low nibble first, then high nibble.
// - Reading the input-pin location returns five live input levels in bits 4:0.
// - On reset assertion the device releases its bus outputs within 50 ns.
// - After reset release the device accepts bus inputs within 1 us.
`ifndef LPC_TARGET_DEFS_VH
`define LPC_TARGET_DEFS_VH

`define LPC_START 4'h0
`define LPC_TYPE_MEM 2'h1
`define LPC_TAR_DRIVE 4'hf
`define LPC_SYNC_READY 4'h0
`define LPC_SYNC_SHORT 4'h5
`define LPC_SYNC_LONG 4'h6
`define LPC_SYNC_ERROR 4'ha
`define LPC_ADDR_NIBBLES 4'h8
`define LPC_PIN_IN_BITS 5
`define LPC_PIN_STATUS_ADDR 32'hffbc_0100
`define LPC_CLK_MHZ 200
`define LPC_RST_FLOAT_NS 50
`define LPC_RST_FLOAT_CYC ((`LPC_RST_FLOAT_NS * `LPC_CLK_MHZ) / 1000)
`define LPC_RST_ACCEPT_US 1
`define LPC_RST_ACCEPT_CYC (`LPC_RST_ACCEPT_US * `LPC_CLK_MHZ)
`define LPC_KRST_US 100

`endif

// ===== testbench/lpc_flash_target_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lpc_flash_target_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Watched outputs
    input wire logic [3:0] lad_out,
    input wire logic lad_oe,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic bus_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic oe_q;
    logic wait_q;
    logic rd_kind;
    // A sync code stands on the bus now; wait codes keep the window open
    wire sync_now = lad_oe && (!oe_q || wait_q);
    // A write pulse marks the cycle as a write until the bus goes idle
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            oe_q <= 1'b0;
            wait_q <= 1'b0;
            rd_kind <= 1'b1;
        end else begin
            oe_q <= lad_oe;
            wait_q <= sync_now && (lad_out == 4'h5 || lad_out == 4'h6);
            rd_kind <= !bus_active ? 1'b1 : mem_wr ? 1'b0 : rd_kind;
        end
    end
    sequence s_done;
        sync_now && (lad_out == 4'h0 || lad_out == 4'ha);
    endsequence
    sequence s_tar;
        lad_oe && lad_out == 4'hf ##1 !lad_oe;
    endsequence
    a_rd_tail: assert property (s_done ##0 rd_kind |=> lad_oe [*2] ##1 s_tar)
        else $error("read tail wrong after sync");
    a_wr_tail: assert property (s_done ##0 !rd_kind |=> s_tar)
        else $error("write turnaround wrong");
    a_sync_code: assert property (sync_now |-> lad_out inside {4'h0, 4'h5, 4'h6, 4'ha})
        else $error("bad sync code");
    a_rd_wait: assert property (mem_rd |-> ##[1:3] (lad_oe && lad_out == 4'h6))
        else $error("no long wait after read request");
    a_wr_wait: assert property (mem_wr |-> ##[1:3] (lad_oe && lad_out == 4'h6))
        else $error("no long wait after write request");
    a_quiet_wake: assert property ($fell(rst) |-> (!lad_oe && !bus_active) [*4])
        else $error("bus driven after reset");
    a_oe_active: assert property (lad_oe |-> bus_active)
        else $error("bus driven while idle");
    a_req_single: assert property (mem_rd || mem_wr |=> !mem_rd && !mem_wr)
        else $error("request not a single pulse");
endmodule
bind lpc_flash_target lpc_flash_target_monitor lpc_flash_target_monitor_inst (
    .clk_sys(clk_sys), .rst(rst), .lad_out(lad_out), .lad_oe(lad_oe),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .bus_active(bus_active));
`default_nettype wire

// ===== testbench/lpc_flash_target_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpc_target_defs.vh"
module lpc_flash_target_tb_top;
    localparam int ACC = 4;
    typedef struct {logic [3:0] t; logic [31:0] a; logic [7:0] wd; logic [7:0] rd;} row_t;
    row_t rows [5] = '{'{4'h4, 32'h1234_5678, 8'h00, 8'h22}, '{4'h5, 32'hffff_fff0, 8'h00, 8'haa},
        '{4'h6, 32'h0000_00a5, 8'h3c, 8'h00}, '{4'h7, 32'h8765_4321, 8'hc3, 8'h00},
        '{4'h4, 32'hffbc_0100, 8'h00, 8'h15}};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] pin_levels = 5'h15;
    logic [7:0] mem_rdata = 8'h00;
    logic mem_ready = 1'b0;
    logic mem_error = 1'b0;
    logic err_mode = 1'b0;
    logic [7:0] w_data = 8'h00;
    logic [7:0] rd;
    logic [3:0] sy;
    wire frame_n, lad_oe, mem_rd, mem_wr, bus_active;
    wire [3:0] lad_in, lad_out;
    wire [31:0] mem_addr;
    wire [7:0] mem_wdata;
    int cnt = 0, lat = 4, n_errors = 0, n_tests = 0, i;
    lpc_flash_target #(.ACCEPT_CYC(ACC)) lpc_flash_target_inst (.clk_sys(clk_sys), .rst(rst),
        .frame_n(frame_n), .lad_in(lad_in), .lad_out(lad_out), .lad_oe(lad_oe),
        .general_purpose_inputs(pin_levels), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
        .mem_error(mem_error), .bus_active(bus_active));
    lpc_host_model lpc_host_model_inst (.clk_sys(clk_sys), .lad_out(lad_out), .lad_oe(lad_oe),
        .frame_n(frame_n), .lad_in(lad_in));
    initial forever #2.5 clk_sys = ~clk_sys;
    // Array stub answers lat clocks after a request; stale status is cleared first
    always @(posedge clk_sys) begin
        if (mem_rd || mem_wr) begin
            cnt <= lat;
            mem_ready <= 1'b0;
            mem_error <= 1'b0;
        end else if (cnt > 0) cnt <= cnt - 1;
        if (cnt == 1) begin
            mem_ready <= !err_mode;
            mem_error <= err_mode;
        end
        mem_rdata <= mem_addr[7:0] ^ 8'h5a;
        if (mem_wr) w_data <= mem_wdata;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic test_done;
        $display("Tests %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, well past the long mid-run reset plus a few hundred clocks
    initial begin
        #200000;
        n_errors++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        chk({lad_oe, bus_active}, 2'b00);
        rst <= 1'b0;
        repeat (ACC + 4) @(posedge clk_sys);
        for (i = 0; i < 5; i++) begin
            lpc_host_model_inst.cycle(rows[i].t, rows[i].a, rows[i].wd, rd, sy);
            chk(sy, 4'h0);
            chk(mem_addr, rows[i].a);
            chk(rows[i].t[1] ? w_data : rd, rows[i].t[1] ? rows[i].wd : rows[i].rd);
        end
        pin_levels <= 5'h0a;
        lpc_host_model_inst.cycle(4'h4, 32'hffbc_0100, 8'h00, rd, sy);
        chk(rd, 8'h0a);
        err_mode <= 1'b1;
        lpc_host_model_inst.cycle(4'h4, 32'h0000_0011, 8'h00, rd, sy);
        chk(sy, 4'ha);
        err_mode <= 1'b0;
        // Non-memory type: the device must stay off the bus
        lpc_host_model_inst.put(4'h0, 1'b0, 1'b1);
        lpc_host_model_inst.put(4'h2, 1'b1, 1'b1);
        lpc_host_model_inst.put(4'hf, 1'b1, 1'b0);
        repeat (20) @(posedge clk_sys) chk(lad_oe, 1'b0);
        // Reset in the middle of a long wait
        lat = 40;
        fork
            lpc_host_model_inst.cycle(4'h4, 32'h0000_0022, 8'h00, rd, sy);
            begin
                repeat (20) @(posedge clk_sys);
                rst <= 1'b1;
                #1 chk(lad_oe, 1'b0);
                // Hold reset the minimum time with the clock already stable
                repeat (`LPC_KRST_US * `LPC_CLK_MHZ) @(posedge clk_sys);
                rst <= 1'b0;
            end
        join
        lat = 4;
        // Let the wake-up window pass, or the next start is ignored
        repeat (ACC + 4) @(posedge clk_sys);
        lpc_host_model_inst.cycle(4'h4, 32'h0000_0033, 8'h00, rd, sy);
        chk(rd, 8'h69);
        test_done;
    end
endmodule
`default_nettype wire

// ===== testbench/lpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model (
    // Clock
    input wire logic clk_sys,
    // Device side of the bus
    input wire logic [3:0] lad_out,
    input wire logic lad_oe,
    // Host side of the bus
    output logic frame_n,
    output wire logic [3:0] lad_in
);
    logic hoe = 1'b0;
    logic [3:0] hnib = 4'h0;
    logic [3:0] last = 4'h0;
    initial frame_n = 1'b1;
    // Undriven bus shows a changing pattern, since no pull-up is assumed
    assign lad_in = lad_oe ? lad_out : hoe ? hnib : ~last;
    always @(posedge clk_sys) last <= lad_in;
    // One host nibble per clock
    task automatic put(input logic [3:0] n, input logic f, input logic oe);
        @(posedge clk_sys);
        hnib <= n;
        hoe <= oe;
        frame_n <= f;
    endtask
    // Full memory cycle as seen by the host
    task automatic cycle(input logic [3:0] t, input logic [31:0] a, input logic [7:0] wd,
            output logic [7:0] rd, output logic [3:0] sy);
        int i;
        rd = 8'h00;
        put(4'h0, 1'b0, 1'b1);
        put(t, 1'b1, 1'b1);
        for (i = 7; i >= 0; i--) put(a[i*4 +: 4], 1'b1, 1'b1);
        if (t[1]) begin
            put(wd[3:0], 1'b1, 1'b1);
            put(wd[7:4], 1'b1, 1'b1);
        end
        put(4'hf, 1'b1, 1'b1);
        put(4'hf, 1'b1, 1'b0);
        i = 0;
        do begin
            @(posedge clk_sys);
            sy = lad_out;
            i++;
        end while (i < 300 && !(lad_oe && sy != 4'h5 && sy != 4'h6));
        if (!t[1]) begin
            @(posedge clk_sys);
            rd[3:0] = lad_out;
            @(posedge clk_sys);
            rd[7:4] = lad_out;
        end
        repeat (2) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire
